// ### shared/freq_alarm_map.vh
// register indexes, field layout, reset values and the limit step for the frequency alarms
`ifndef FREQ_ALARM_MAP_VH
`define FREQ_ALARM_MAP_VH

// register word indexes; byte address is four times the index
`define IDX_LIMITS_ALL 10'h049
`define IDX_LIMITS_SEL 10'h04a
`define IDX_MON_CTRL 10'h060
`define IDX_ALARM_STATUS 10'h061
`define IDX_IRQ_STATUS 10'h062
`define IDX_IRQ_MASK 10'h063

// nibble layout of both limit registers
`define LIM_SOFT_HI 7
`define LIM_SOFT_LO 4
`define LIM_HARD_HI 3
`define LIM_HARD_LO 0
`define LIM_WIDTH 8

// reset values: soft code 2, hard code 3
`define LIMITS_RESET 8'h23

// monitor control bits
`define CTRL_HARD_EN 0
`define CTRL_SOFT_EN 1
`define CTRL_WIDTH 2
`define CTRL_RESET 2'h3

// status and interrupt layout: soft alarms from bit 0, hard alarms from bit 16
`define STAT_SOFT_LSB 0
`define STAT_HARD_LSB 16

// one threshold step is 3.81 ppm, held in units of 0.01 ppm
`define STEP_PPM_X100 381

`endif

// ### rtl/freq_limit_compare.v
// one reference input: symmetric soft and hard limit check of a measured frequency offset
`timescale 1ns/1ps
`default_nettype none
`include "freq_alarm_map.vh"

module freq_limit_compare #(
	parameter OW = 16
) (
	input wire pclk,
	input wire presetn,
	input wire offset_valid,
	input wire [OW-1:0] offset,
	input wire [3:0] soft_code,
	input wire [3:0] hard_code,
	input wire soft_en,
	input wire hard_en,
	output reg soft_alarm_q,
	output reg hard_alarm_q
);
	// offset is two's complement in 0.01 ppm; OW must be at least 14 to hold the widest limit
	localparam integer STEP_INT = `STEP_PPM_X100;
	localparam [OW:0] STEP = STEP_INT[OW:0];
	localparam [OW:0] ONE = {{OW{1'b0}}, 1'b1};

	wire signed [OW:0] off_x = {offset[OW-1], offset};
	wire [OW:0] soft_lim = ({{(OW-3){1'b0}}, soft_code} + ONE) * STEP; // see RULE_01
	wire [OW:0] hard_lim = ({{(OW-3){1'b0}}, hard_code} + ONE) * STEP; // see RULE_01
	// the sign-extended offset never overflows against a negated positive limit
	wire soft_over = (off_x > $signed(soft_lim)) || (off_x < -$signed(soft_lim)); // see RULE_02
	wire hard_over = (off_x > $signed(hard_lim)) || (off_x < -$signed(hard_lim)); // see RULE_02

	reg soft_alarm_d;
	reg hard_alarm_d;

	// a disabled monitor drops its alarm at once instead of waiting for the next measurement
	always @* begin
		if (offset_valid) begin
			soft_alarm_d = soft_en & soft_over; // see RULE_07
			hard_alarm_d = hard_en & hard_over; // see RULE_07
		end else begin
			soft_alarm_d = soft_alarm_q & soft_en; // see RULE_07
			hard_alarm_d = hard_alarm_q & hard_en; // see RULE_07
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_alarm_q <= 1'b0;
			hard_alarm_q <= 1'b0;
		end else begin
			soft_alarm_q <= soft_alarm_d;
			hard_alarm_q <= hard_alarm_d;
		end
	end
endmodule
`default_nettype wire

// ### rtl/freq_alarm_threshold_config.v
// frequency alarm limit registers, per-input limit checks and alarm interrupts behind APB
// How it works
// RULE_01: limit in ppm is threshold code plus one, times 3.81 ppm.
// RULE_02: alarm when offset exceeds the limit, positive or negative.
// RULE_03: general register: high nibble soft limit, low nibble hard limit, all inputs.
// RULE_04: soft code resets to two, plus or minus 11.43 ppm.
// RULE_05: hard code resets to three, four steps each side of zero.
// RULE_06: separate register's limits replace general ones for the selected reference only.
// RULE_07: soft and hard alarms reported only while their monitor enable is set.
// RULE_08: hard alarm makes an input unavailable; soft alarm only flags status.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "freq_alarm_map.vh"

module freq_alarm_threshold_config #(
	parameter NUM_INPUTS = 4,
	parameter OW = 16,
	parameter SW = 2
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [NUM_INPUTS-1:0] offset_valid,
	input wire [NUM_INPUTS*OW-1:0] offset,
	input wire sel_valid,
	input wire [SW-1:0] sel_index,
	output wire [NUM_INPUTS-1:0] soft_alarm,
	output wire [NUM_INPUTS-1:0] hard_alarm,
	output wire [NUM_INPUTS-1:0] input_available,
	output wire irq
);
	reg [`LIM_WIDTH-1:0] lim_all_q;
	reg [`LIM_WIDTH-1:0] lim_all_d;
	reg [`LIM_WIDTH-1:0] lim_sel_q;
	reg [`LIM_WIDTH-1:0] lim_sel_d;
	reg [`CTRL_WIDTH-1:0] ctrl_q;
	reg [`CTRL_WIDTH-1:0] ctrl_d;
	reg [31:0] irq_stat_q;
	reg [31:0] irq_stat_d;
	reg [31:0] irq_mask_q;
	reg [31:0] irq_mask_d;
	reg [NUM_INPUTS-1:0] soft_prev_q;
	reg [NUM_INPUTS-1:0] hard_prev_q;
	reg [31:0] rdata_d;
	reg decode_hit;

	wire [NUM_INPUTS-1:0] soft_raw;
	wire [NUM_INPUTS-1:0] hard_raw;
	wire [9:0] idx = paddr[11:2];
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire wr = access & pwrite & decode_hit;
	wire [31:0] alarm_word;
	wire [31:0] events;

	// one strobe per register keeps each register's next-value logic on its own
	wire wr_lim_all = wr && (idx == `IDX_LIMITS_ALL);
	wire wr_lim_sel = wr && (idx == `IDX_LIMITS_SEL);
	wire wr_ctrl = wr && (idx == `IDX_MON_CTRL);
	wire wr_irq_stat = wr && (idx == `IDX_IRQ_STATUS);
	wire wr_irq_mask = wr && (idx == `IDX_IRQ_MASK);
	wire rd_setup = setup && !pwrite;

	// monitor enables, shared by every input
	wire soft_en = ctrl_q[`CTRL_SOFT_EN];
	wire hard_en = ctrl_q[`CTRL_HARD_EN];

	// an alarm counts as an event only on its rising edge, so a standing alarm
	// does not set its status bit again straight after software clears it
	wire [NUM_INPUTS-1:0] soft_rise = soft_raw & ~soft_prev_q;
	wire [NUM_INPUTS-1:0] hard_rise = hard_raw & ~hard_prev_q;

	// register and status words, zero-padded to the bus width
	wire [31:0] lim_all_word = {{(32-`LIM_WIDTH){1'b0}}, lim_all_q};
	wire [31:0] lim_sel_word = {{(32-`LIM_WIDTH){1'b0}}, lim_sel_q};
	wire [31:0] ctrl_word = {{(32-`CTRL_WIDTH){1'b0}}, ctrl_q};
	wire [31:0] soft_word = {{(32-NUM_INPUTS){1'b0}}, soft_raw};
	wire [31:0] hard_word = {{(32-NUM_INPUTS){1'b0}}, hard_raw};
	wire [31:0] soft_rise_word = {{(32-NUM_INPUTS){1'b0}}, soft_rise};
	wire [31:0] hard_rise_word = {{(32-NUM_INPUTS){1'b0}}, hard_rise};
	wire [31:0] irq_pending = irq_stat_q & irq_mask_q;

	// zero wait states: read data is captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = access & ~decode_hit;

	always @* begin
		decode_hit = 1'b1;
		rdata_d = 32'h0000_0000;
		case (idx)
			`IDX_LIMITS_ALL: begin
				rdata_d = lim_all_word;
			end
			`IDX_LIMITS_SEL: begin
				rdata_d = lim_sel_word;
			end
			`IDX_MON_CTRL: begin
				rdata_d = ctrl_word;
			end
			`IDX_ALARM_STATUS: begin
				rdata_d = alarm_word;
			end
			`IDX_IRQ_STATUS: begin
				rdata_d = irq_stat_q;
			end
			`IDX_IRQ_MASK: begin
				rdata_d = irq_mask_q;
			end
			default: begin
				decode_hit = 1'b0;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= rdata_d;
		end
	end

	// only the low limit and control register bits are stored; upper write data bits are dropped, the mask keeps all 32
	always @* begin
		lim_all_d = lim_all_q;
		if (wr_lim_all) begin
			lim_all_d = pwdata[`LIM_WIDTH-1:0]; // see RULE_03
		end
	end

	always @* begin
		lim_sel_d = lim_sel_q;
		if (wr_lim_sel) begin
			lim_sel_d = pwdata[`LIM_WIDTH-1:0]; // see RULE_06
		end
	end

	always @* begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d = pwdata[`CTRL_WIDTH-1:0]; // see RULE_07
		end
	end

	always @* begin
		irq_mask_d = irq_mask_q;
		if (wr_irq_mask) begin
			irq_mask_d = pwdata;
		end
	end

	// a new alarm in the same cycle as its write-one-to-clear survives the clear
	always @* begin
		irq_stat_d = irq_stat_q;
		if (wr_irq_stat) begin
			irq_stat_d = irq_stat_q & ~pwdata;
		end
		irq_stat_d = irq_stat_d | events;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lim_all_q <= `LIMITS_RESET; // see RULE_04 and RULE_05
		end else begin
			lim_all_q <= lim_all_d;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lim_sel_q <= `LIMITS_RESET; // see RULE_04 and RULE_05
		end else begin
			lim_sel_q <= lim_sel_d;
		end
	end

	// both monitors come out of reset enabled
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= 32'h0000_0000;
		end else begin
			irq_stat_q <= irq_stat_d;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_q <= 32'h0000_0000;
		end else begin
			irq_mask_q <= irq_mask_d;
		end
	end

	// previous alarm levels for the rising-edge event detect; idle level is no alarm
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_prev_q <= {NUM_INPUTS{1'b0}};
		end else begin
			soft_prev_q <= soft_raw;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hard_prev_q <= {NUM_INPUTS{1'b0}};
		end else begin
			hard_prev_q <= hard_raw;
		end
	end

	genvar i;
	generate
		for (i = 0; i < NUM_INPUTS; i = i + 1) begin : g_in
			// the selected reference is checked against its own limits
			wire use_sel = sel_valid && (sel_index == i); // see RULE_06
			wire [`LIM_WIDTH-1:0] lim = use_sel ? lim_sel_q : lim_all_q; // see RULE_06
			freq_limit_compare #(
				.OW(OW)
			) u_cmp (
				.pclk(pclk),
				.presetn(presetn),
				.offset_valid(offset_valid[i]),
				.offset(offset[i*OW +: OW]),
				.soft_code(lim[`LIM_SOFT_HI:`LIM_SOFT_LO]), // see RULE_03
				.hard_code(lim[`LIM_HARD_HI:`LIM_HARD_LO]), // see RULE_03
				.soft_en(soft_en),
				.hard_en(hard_en),
				.soft_alarm_q(soft_raw[i]),
				.hard_alarm_q(hard_raw[i])
			);
		end
	endgenerate

	assign soft_alarm = soft_raw;
	assign hard_alarm = hard_raw;
	// only a hard alarm takes an input out of selection
	assign input_available = ~hard_raw; // see RULE_08

	assign alarm_word = (soft_word << `STAT_SOFT_LSB) | (hard_word << `STAT_HARD_LSB);
	assign events = (soft_rise_word << `STAT_SOFT_LSB) | (hard_rise_word << `STAT_HARD_LSB);
	assign irq = |irq_pending;
endmodule
`default_nettype wire

// ### tb/freq_alarm_checker.sv
// port checker for the frequency alarm limit block
`timescale 1ns/1ps
`default_nettype none
`include "freq_alarm_map.vh"
module freq_alarm_checker #(parameter NUM_INPUTS = 4, parameter OW = 16, parameter SW = 2) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic [NUM_INPUTS-1:0] offset_valid,
	input wire logic [NUM_INPUTS*OW-1:0] offset,
	input wire logic sel_valid,
	input wire logic [SW-1:0] sel_index,
	input wire logic [NUM_INPUTS-1:0] soft_alarm,
	input wire logic [NUM_INPUTS-1:0] hard_alarm,
	input wire logic [NUM_INPUTS-1:0] input_available
);
	// shadows follow apb writes; input 0 is judged only while it uses the general limits
	logic [7:0] all_q;
	logic [1:0] en_q;
	wire logic acc = psel && penable;
	wire logic own = offset_valid[0] && !(sel_valid && sel_index == 0);
	wire logic signed [OW:0] ox = $signed(offset[OW-1:0]);
	wire logic [OW:0] mag = ox < 0 ? -ox : ox;
	wire logic soft_hit = en_q[1] && mag > (all_q[7:4] + 32'h1) * `STEP_PPM_X100;
	wire logic hard_hit = en_q[0] && mag > (all_q[3:0] + 32'h1) * `STEP_PPM_X100;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			all_q <= `LIMITS_RESET;
			en_q <= `CTRL_RESET;
		end else if (acc && pwrite) begin
			if (paddr == {`IDX_LIMITS_ALL, 2'h0})
				all_q <= pwdata[7:0];
			if (paddr == {`IDX_MON_CTRL, 2'h0})
				en_q <= pwdata[1:0];
		end
	end
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_soft_lim: assert property (own |=> soft_alarm[0] == $past(soft_hit))
		else $error("soft alarm");
	a_hard_lim: assert property (own |=> hard_alarm[0] == $past(hard_hit))
		else $error("hard alarm");
	a_avail_hard: assert property (input_available == ~hard_alarm)
		else $error("available");
	a_soft_off: assert property ((!en_q[1])[*3] |-> soft_alarm == '0)
		else $error("soft enable");
	a_hard_off: assert property ((!en_q[0])[*3] |-> hard_alarm == '0)
		else $error("hard enable");
	a_all_read: assert property (acc && !pwrite && paddr == {`IDX_LIMITS_ALL, 2'h0}
		|-> prdata == {24'h0, all_q}) else $error("limits read");
	a_bad_read: assert property (acc && !pwrite && paddr[11:9] != 3'h0 |-> prdata == 32'h0)
		else $error("unmapped read");
	a_alarm_hold: assert property (!offset_valid[0] && !acc && $stable(en_q)
		|=> $stable(soft_alarm[0])) else $error("alarm hold");
endmodule
bind freq_alarm_threshold_config freq_alarm_checker #(.NUM_INPUTS(NUM_INPUTS), .OW(OW), .SW(SW))
	chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .offset_valid,
	.offset, .sel_valid, .sel_index, .soft_alarm, .hard_alarm, .input_available);
`default_nettype wire

// ### tb/freq_alarm_threshold_config_tb_top.sv
// bench for the frequency alarm limit block
`timescale 1ns/1ps
`default_nettype none
`include "freq_alarm_map.vh"
module freq_alarm_threshold_config_tb_top;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic sel_valid = 1'h0, pready, pslverr, irq;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] offset_valid = 4'h0, soft_alarm, hard_alarm, input_available;
	logic [63:0] offset = 64'h0;
	logic [1:0] sel_index = 2'h1;
	int miscompares = 0, n_tests = 0;
	always #5 pclk = ~pclk;
	freq_alarm_threshold_config DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .offset_valid, .offset, .sel_valid, .sel_index,
		.soft_alarm, .hard_alarm, .input_available, .irq);
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// reads compare against d, so one task serves both directions
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {a, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		chk("pslverr", 32'(!(a inside {`IDX_LIMITS_ALL, `IDX_LIMITS_SEL, `IDX_MON_CTRL,
			`IDX_ALARM_STATUS, `IDX_IRQ_STATUS, `IDX_IRQ_MASK})), 32'(pslverr));
		if (!w)
			chk("prdata", d, prdata);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task mchk(input int i, input logic [15:0] v, input logic [1:0] e);
		@(posedge pclk);
		offset_valid[i] <= 1'h1;
		offset[i*16+:16] <= v;
		@(posedge pclk);
		offset_valid[i] <= 1'h0;
		@(negedge pclk);
		chk("soft", 32'(e[1]), 32'(soft_alarm[i]));
		chk("hard", 32'(e[0]), 32'(hard_alarm[i]));
		chk("avail", 32'(!e[0]), 32'(input_available[i]));
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge pclk);
		miscompares++;
		end_sim;
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, `IDX_LIMITS_ALL, 32'h23);
		apb(1'h0, `IDX_LIMITS_SEL, 32'h23);
		apb(1'h0, `IDX_MON_CTRL, 32'h3);
		mchk(0, 16'h477, 2'h0);
		mchk(0, -16'h478, 2'h2);
		mchk(0, 16'h5f4, 2'h2);
		mchk(0, -16'h5f5, 2'h3);
		apb(1'h1, `IDX_LIMITS_ALL, 32'hffffff50);
		apb(1'h0, `IDX_LIMITS_ALL, 32'h50);
		mchk(0, -16'h190, 2'h1);
		apb(1'h1, `IDX_LIMITS_SEL, 32'h1);
		sel_valid <= 1'h1;
		mchk(1, 16'h1f4, 2'h2);
		mchk(0, 16'h1f4, 2'h1);
		apb(1'h0, `IDX_ALARM_STATUS, 32'h10002);
		@(posedge pclk) sel_index <= 2'h0;
		mchk(0, 16'h1f4, 2'h2);
		mchk(1, 16'h1f4, 2'h1);
		@(posedge pclk) sel_index <= 2'h1;
		apb(1'h1, `IDX_MON_CTRL, 32'h0);
		mchk(0, 16'h1388, 2'h0);
		apb(1'h1, `IDX_MON_CTRL, 32'h2);
		mchk(0, 16'h1388, 2'h2);
		mchk(0, 16'h0, 2'h0);
		apb(1'h1, `IDX_IRQ_STATUS, 32'hffffffff);
		apb(1'h1, `IDX_IRQ_MASK, 32'h1);
		apb(1'h0, `IDX_IRQ_MASK, 32'h1);
		mchk(0, 16'h1388, 2'h2);
		@(negedge pclk);
		chk("irq", 32'h1, 32'(irq));
		apb(1'h0, `IDX_IRQ_STATUS, 32'h1);
		apb(1'h1, `IDX_IRQ_STATUS, 32'h1);
		@(negedge pclk);
		chk("irq", 32'h0, 32'(irq));
		apb(1'h0, 10'h080, 32'h0);
		end_sim;
	end
endmodule
`default_nettype wire
